// ===== dv/otp_memory_controller_tb.sv
// Self-checking bench for the memory controller.
// Assumes the macro model on the far side and a 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module otp_memory_controller_tb;
	import otpmc_pkg::*;
	typedef struct {logic [5:0] off; logic [31:0] rst; logic [31:0] ones;} otpmc_row_type;
	otpmc_row_type rows [12] = '{'{6'h04, 32'h0, 32'h1}, '{6'h08, 32'h0, 32'h1},
		'{6'h0C, 32'h0, 32'h1}, '{6'h10, 32'h0, 32'h1}, '{6'h14, 32'h0, 32'hFFFF},
		'{6'h18, 32'h0, 32'hF}, '{6'h1C, 32'h0, 32'hF}, '{6'h20, 32'h1, 32'h1},
		'{6'h24, 32'h0, 32'h1}, '{6'h28, 32'h0, 32'hFFF}, '{6'h2C, 32'h0, 32'hFFFFFFFF},
		'{6'h34, 32'h1, 32'h3F}};
	logic [5:0]  tims [6] = '{6'h01, 6'h00, 6'h08, 6'h10, 6'h20, 6'h3F};
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  c_addr = 6'h0;
	logic        c_rd = 1'b0;
	logic        c_wr = 1'b0;
	logic [31:0] c_wd = 32'h0;
	logic [3:0]  c_be = 4'hF;
	logic [31:0] c_rdata;
	logic        c_wait;
	logic [13:0] a_addr = 14'h0;
	logic        a_rd = 1'b0;
	logic        a_wr = 1'b0;
	logic [31:0] a_rdata;
	logic        a_wait;
	logic        m_ck, m_oe, m_sel, m_we, vrr_en, vpp_en;
	logic [15:0] m_mode;
	logic [11:0] m_addr;
	logic [31:0] m_wd, m_rdata;
	logic [3:0]  m_rr, m_pp;
	logic [31:0] q;
	int          n;
	int          errors = 0;
	int          check_count = 0;

	otpmc_controller dut (.core_clk_in(core_clk), .rst_in(rst), .ctl_address_in(c_addr),
		.ctl_read_in(c_rd), .ctl_write_in(c_wr), .ctl_writedata_in(c_wd), .ctl_byteenable_in(c_be),
		.ctl_readdata_out(c_rdata), .ctl_waitrequest_out(c_wait), .arr_address_in(a_addr),
		.arr_read_in(a_rd), .arr_write_in(a_wr), .arr_readdata_out(a_rdata),
		.arr_waitrequest_out(a_wait), .macro_clock_out(m_ck), .macro_output_enable_out(m_oe),
		.macro_select_out(m_sel), .macro_write_enable_out(m_we), .macro_mode_out(m_mode),
		.macro_address_out(m_addr), .macro_write_data_out(m_wd), .macro_read_data_in(m_rdata),
		.read_regulator_out(m_rr), .charge_pump_out(m_pp), .read_voltage_enable_out(vrr_en),
		.write_voltage_enable_out(vpp_en));
	otpmc_macro_model macro (.core_clk_in(core_clk), .oe_in(m_oe), .sel_in(m_sel),
		.addr_in(m_addr), .data_out(m_rdata));

	always #50 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ctl(input logic w, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] r);
		@(posedge core_clk);
		c_addr <= a;
		c_rd <= !w;
		c_wr <= w;
		c_wd <= d;
		c_be <= be;
		do @(posedge core_clk); while (c_wait !== 1'b0);
		r = c_rdata;
		c_rd <= 1'b0;
		c_wr <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		ctl(1'b1, a, d, 4'hF, r);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ctl(1'b0, a, 32'h0, 4'hF, r);
		chk(r, exp);
	endtask
	// Counts edges from raising the request to the answer edge
	task automatic arr(input logic w, input logic [13:0] a, output logic [31:0] r, output int k);
		@(posedge core_clk);
		a_addr <= a;
		a_rd <= !w;
		a_wr <= w;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (a_wait !== 1'b0);
		r = a_rdata;
		a_rd <= 1'b0;
		a_wr <= 1'b0;
	endtask
	function automatic int plen(input logic [5:0] t);
		return (1 << t[2:0]) * (3 + 2 * t[3] + 2 * t[4] + 2 * t[5]);
	endfunction
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		arr(1'b0, 14'h048C, q, n);
		chk(q, 32'hC3A50123);
		chk(n, plen(6'h01) + 2);
		rd(6'h00, 32'h0);
		for (int i = 0; i < 12; i++) rd(rows[i].off, rows[i].rst);
		for (int i = 0; i < 6; i++) begin
			wr(6'h00, 32'h1);
			wr(6'h34, {26'h0, tims[i]});
			wr(6'h00, 32'h0);
			arr(1'b0, {i[11:0], 2'b00}, q, n);
			chk(q, {20'hC3A50, i[11:0]});
			chk(n, plen(tims[i]) + 2);
		end
		arr(1'b1, 14'h0010, q, n);
		chk(n, 2);
		chk(m_we, 1'b0);
		fork
			arr(1'b0, 14'h0020, q, n);
			begin
				repeat (3) @(posedge core_clk);
				wr(6'h00, 32'h1);
			end
		join
		chk(q, 32'hC3A50008);
		rd(6'h00, 32'h0);
		wr(6'h00, 32'h1);
		rd(6'h00, 32'h1);
		arr(1'b0, 14'h0020, q, n);
		chk(q, 32'h0);
		chk(n, 2);
		for (int i = 0; i < 12; i++) begin
			wr(rows[i].off, 32'hFFFFFFFF);
			rd(rows[i].off, rows[i].ones);
		end
		chk({m_ck, m_oe, m_sel, m_we, vrr_en, vpp_en}, 6'h3F);
		chk({m_mode, m_addr, m_rr}, 32'hFFFFFFFF);
		chk(m_pp, 4'hF);
		chk(m_wd, 32'hFFFFFFFF);
		wr(6'h30, 32'h0);
		rd(6'h30, 32'hC3A50FFF);
		ctl(1'b1, 6'h1C, 32'h0, 4'h3, q);
		rd(6'h1C, 32'hF);
		wr(6'h38, 32'hFFFFFFFF);
		rd(6'h38, 32'h0);
		rd(6'h3C, 32'h0);
		for (int i = 0; i < 12; i++) wr(rows[i].off, rows[i].rst);
		wr(6'h00, 32'h0);
		rd(6'h00, 32'h0);
		chk({m_we, vrr_en, m_pp}, 6'h10);
		// One bit pulsed with write enable low and write supply off, verified at margin, soaked and verified again
		wr(6'h00, 32'h1);
		rd(6'h00, 32'h1);
		wr(6'h18, 32'h4);
		wr(6'h1C, 32'h0);
		wr(6'h24, 32'h0);
		repeat (200) @(posedge core_clk);
		wr(6'h28, 32'h5A5);
		wr(6'h2C, 32'h10);
		wr(6'h04, 32'h1);
		chk({m_ck, m_addr, m_rr}, {1'b1, 12'h5A5, 4'h4});
		chk(m_wd, 32'h10);
		repeat (500) @(posedge core_clk);
		wr(6'h04, 32'h0);
		chk(m_ck, 1'b0);
		wr(6'h18, 32'h9);
		// Enable before select, so the pin order differs from a sequencer read
		wr(6'h08, 32'h1);
		wr(6'h0C, 32'h1);
		rd(6'h30, 32'hC3A505A5);
		wr(6'h18, 32'h4);
		wr(6'h04, 32'h1);
		repeat (4000) @(posedge core_clk);
		wr(6'h04, 32'h0);
		wr(6'h18, 32'hF);
		rd(6'h30, 32'hC3A505A5);
		chk(m_rr, 4'hF);
		// Reset in mid-run drops ownership and every software setting
		rst <= 1'b1;
		repeat (RESET_HOLD_CYCLES) @(posedge core_clk);
		chk({c_wait, a_wait, vrr_en, vpp_en, m_oe, m_sel, m_rr}, 10'h380);
		rst <= 1'b0;
		arr(1'b0, 14'h0024, q, n);
		chk(q, 32'hC3A50009);
		chk(n, plen(6'h01) + 2);
		rd(6'h00, 32'h0);
		rd(6'h34, 32'h1);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire

// ===== dv/otpmc_assertions.sv
// Port checks for the memory controller.
// Assumes masters keep the Avalon-MM handshake.
`timescale 1ns/100ps
`default_nettype none
module otpmc_assertions
	import otpmc_pkg::*;
#(
	parameter int MPP_W = 4
) (
	input wire logic                         core_clk_in,
	input wire logic                         rst_in,
	input wire logic [otpmc_pkg::CTL_AW-1:0] ctl_address_in,
	input wire logic                         ctl_read_in,
	input wire logic                         ctl_write_in,
	input wire logic [31:0]                  ctl_readdata_out,
	input wire logic                         ctl_waitrequest_out,
	input wire logic                         arr_waitrequest_out,
	input wire logic                         macro_clock_out,
	input wire logic                         macro_output_enable_out,
	input wire logic                         macro_select_out,
	input wire logic                         macro_write_enable_out,
	input wire logic [MPP_W-1:0]             charge_pump_out,
	input wire logic                         read_voltage_enable_out
);
	import otpmc_pkg::*;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// Read supply stays on through reset so a read may follow release at once
	vrren_in_reset_a: assert property (
		disable iff (1'b0) rst_in |=> read_voltage_enable_out)
		else $error("read supply off in reset");
	ctl_answer_time_a: assert property (
		(ctl_read_in || ctl_write_in) && ctl_waitrequest_out |=> !ctl_waitrequest_out)
		else $error("register answer late");
	ctl_answer_once_a: assert property (
		!ctl_waitrequest_out |=> ctl_waitrequest_out)
		else $error("register answer too long");
	arr_answer_once_a: assert property (
		!arr_waitrequest_out |=> arr_waitrequest_out)
		else $error("array answer too long");
	unmapped_zero_a: assert property (
		ctl_read_in && ctl_waitrequest_out && ctl_address_in[5:2] > 4'hD
		|=> ctl_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	// Aimed at sequencer reads; software raises output enable before select
	phase_order_a: assert property (
		$rose(macro_output_enable_out) && macro_select_out |-> $past(macro_clock_out))
		else $error("access phase without pulse phase");
	// Pins move at the very edge that takes the register write
	we_follows_a: assert property (
		$changed(macro_write_enable_out) |-> $past(ctl_write_in))
		else $error("write enable moved without write");
	pump_follows_a: assert property (
		$changed(charge_pump_out) |-> $past(ctl_write_in))
		else $error("pump control moved without write");
endmodule
bind otpmc_controller otpmc_assertions #(.MPP_W(MPP_W)) u_chk (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .ctl_address_in(ctl_address_in),
	.ctl_read_in(ctl_read_in), .ctl_write_in(ctl_write_in), .ctl_readdata_out(ctl_readdata_out),
	.ctl_waitrequest_out(ctl_waitrequest_out), .arr_waitrequest_out(arr_waitrequest_out),
	.macro_clock_out(macro_clock_out), .macro_output_enable_out(macro_output_enable_out),
	.macro_select_out(macro_select_out), .macro_write_enable_out(macro_write_enable_out),
	.charge_pump_out(charge_pump_out), .read_voltage_enable_out(read_voltage_enable_out));
`default_nettype wire

// ===== dv/otpmc_macro_model.sv
// Behavioural memory macro: word pattern from the address.
// Assumes select and output enable high while read data is wanted.
`timescale 1ns/100ps
`default_nettype none
module otpmc_macro_model #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 32
) (
	input wire logic              core_clk_in,
	input wire logic              oe_in,
	input wire logic              sel_in,
	input wire logic [ADDR_W-1:0] addr_in,
	output logic [DATA_W-1:0]     data_out
);
	logic [DATA_W-1:0] idle_reg;
	// Undriven bus flips every cycle so stale data never looks valid
	always_ff @(posedge core_clk_in) begin
		idle_reg <= ~data_out;
	end
	assign data_out = (oe_in && sel_in) ? DATA_W'({20'hC3A50, addr_in}) : idle_reg;
endmodule
`default_nettype wire

// ===== rtl/otpmc_controller.sv
// One-time programmable memory controller: control registers and read sequencer.
// Assumes a macro with registered-in controls and a combinational read data bus.
// What this block does
// - Read supply on in reset; reads work afterwards
// - Only aligned 32-bit register accesses needed
// - Array region readable, writes have no effect
// - Ownership set: array reads return 0 at once
// - Ownership request refused while array read runs
// - Each register but lock and timing maps onto one macro signal; ck, oe, sel, we, addr and wdata reach their pins only while lock is set
// - Read is setup, pulse, then access phase
// - Phase is 2^scale cycles, tripled if stretched
// - Timing: scale [2:0] reset 1, stretch bits 3-5
`timescale 1ns/100ps
`default_nettype none
module otpmc_controller
	import otpmc_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 32,
	parameter int MR_W   = 16,
	parameter int MRR_W  = 4,
	parameter int MPP_W  = 4
) (
	// Clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	// Control register bus
	input  wire logic [CTL_AW-1:0] ctl_address_in,
	input  wire logic              ctl_read_in,
	input  wire logic              ctl_write_in,
	input  wire logic [31:0]       ctl_writedata_in,
	input  wire logic [3:0]        ctl_byteenable_in,
	output logic [31:0]            ctl_readdata_out,
	output logic                   ctl_waitrequest_out,
	// Array read region
	input  wire logic [ADDR_W+1:0] arr_address_in,
	input  wire logic              arr_read_in,
	input  wire logic              arr_write_in,
	output logic [DATA_W-1:0]      arr_readdata_out,
	output logic                   arr_waitrequest_out,
	// Memory macro
	output logic                   macro_clock_out,
	output logic                   macro_output_enable_out,
	output logic                   macro_select_out,
	output logic                   macro_write_enable_out,
	output logic [MR_W-1:0]        macro_mode_out,
	output logic [ADDR_W-1:0]      macro_address_out,
	output logic [DATA_W-1:0]      macro_write_data_out,
	input  wire logic [DATA_W-1:0] macro_read_data_in,
	// Supply controls
	output logic [MRR_W-1:0]       read_regulator_out,
	output logic [MPP_W-1:0]       charge_pump_out,
	output logic                   read_voltage_enable_out,
	output logic                   write_voltage_enable_out
);
	import otpmc_pkg::*;

	typedef struct packed {
		logic                  ctl_wait;
		logic [31:0]           ctl_rdata;
		logic                  arr_wait;
		logic [DATA_W-1:0]     arr_rdata;
		otpmc_state_type       state;
		logic [ADDR_W-1:0]     seq_addr;
		logic                  lock;
		logic                  ck;
		logic                  oe;
		logic                  sel;
		logic                  we;
		logic [MR_W-1:0]       mr;
		logic [MRR_W-1:0]      mrr;
		logic [MPP_W-1:0]      mpp;
		logic                  vrren;
		logic                  vppen;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
		logic [DATA_W-1:0]     q;
		logic [TIM_W-1:0]      timing;
		logic                  pin_ck;
		logic                  pin_oe;
		logic                  pin_sel;
		logic                  pin_we;
		logic [MR_W-1:0]       pin_mr;
		logic [ADDR_W-1:0]     pin_addr;
		logic [DATA_W-1:0]     pin_wdata;
		logic [MRR_W-1:0]      pin_mrr;
		logic [MPP_W-1:0]      pin_mpp;
		logic                  pin_vrren;
		logic                  pin_vppen;
	} otpmc_ctrl_type;

	otpmc_ctrl_type     ctrl_reg;
	otpmc_ctrl_type     ctrl_next;
	logic               tmr_load;
	logic [PHASE_W-1:0] tmr_len;
	logic               tmr_expired;

	// Word decode on the byte address; low two bits are ignored
	function automatic logic hits(input logic [CTL_AW-1:0] a, input logic [CTL_AW-1:0] off);
		hits = (a[CTL_AW-1:WORD_LSB] == off[CTL_AW-1:WORD_LSB]);
	endfunction

	function automatic logic [PHASE_W-1:0] phase_len(input logic [TIM_W-1:0] t,
			input logic stretch);
		logic [PHASE_W-1:0] base;
		base = PHASE_W'(1) << t[TIM_SCALE_LSB +: TIM_SCALE_W];
		phase_len = stretch ? PHASE_W'(base + (base << 1)) : base;
	endfunction

	otpmc_phase_timer u_timer (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (tmr_load),
		.len_in      (tmr_len),
		.expired_out (tmr_expired)
	);

	always_comb begin
		logic ctl_take;
		logic ctl_wr;
		logic arr_take;
		logic seq_start;
		logic [CTL_AW-1:0] a;
		ctl_take  = 1'b0;
		ctl_wr    = 1'b0;
		arr_take  = 1'b0;
		seq_start = 1'b0;
		a         = ctl_address_in;
		ctrl_next = ctrl_reg;
		tmr_load  = 1'b0;
		tmr_len   = PHASE_W'(1);

		// Macro output is sampled every cycle so software sees live read data
		ctrl_next.q = macro_read_data_in;

		// Array region: one request at a time, answered by a one-cycle low wait
		ctrl_next.arr_wait = 1'b1;
		arr_take = (arr_read_in || arr_write_in) && ctrl_reg.arr_wait &&
			(ctrl_reg.state == ST_IDLE);
		case (ctrl_reg.state)
			ST_IDLE: begin
				if (arr_take) begin
					if (arr_write_in || ctrl_reg.lock) begin
						ctrl_next.arr_wait  = 1'b0;
						ctrl_next.arr_rdata = '0;
					end else begin
						seq_start          = 1'b1;
						ctrl_next.seq_addr = arr_address_in[ADDR_W+1:WORD_LSB];
						ctrl_next.state    = ST_SETUP;
						tmr_load           = 1'b1;
						tmr_len            = phase_len(ctrl_reg.timing,
							ctrl_reg.timing[TIM_SETUP_BIT]);
					end
				end
			end
			ST_SETUP: begin
				if (tmr_expired) begin
					ctrl_next.state = ST_PULSE;
					tmr_load        = 1'b1;
					tmr_len         = phase_len(ctrl_reg.timing,
						ctrl_reg.timing[TIM_PULSE_BIT]);
				end
			end
			ST_PULSE: begin
				if (tmr_expired) begin
					ctrl_next.state = ST_ACCESS;
					tmr_load        = 1'b1;
					tmr_len         = phase_len(ctrl_reg.timing,
						ctrl_reg.timing[TIM_ACCESS_BIT]);
				end
			end
			ST_ACCESS: begin
				if (tmr_expired) begin
					ctrl_next.arr_rdata = macro_read_data_in;
					ctrl_next.arr_wait  = 1'b0;
					ctrl_next.state     = ST_DONE;
				end
			end
			ST_DONE: begin
				ctrl_next.state = ST_IDLE;
			end
			default: begin
				ctrl_next.state = ST_IDLE;
			end
		endcase

		// Control bus: each request is answered one cycle after it is seen
		ctl_take = (ctl_read_in || ctl_write_in) && ctrl_reg.ctl_wait;
		ctrl_next.ctl_wait = !ctl_take;
		// Partial writes are dropped; software only ever needs full words
		ctl_wr = ctl_take && ctl_write_in && (ctl_byteenable_in == FULL_WORD);

		if (ctl_take && ctl_read_in) begin
			ctrl_next.ctl_rdata = '0;
			if (hits(a, OFF_LOCK))   ctrl_next.ctl_rdata = 32'(ctrl_reg.lock);
			if (hits(a, OFF_CK))     ctrl_next.ctl_rdata = 32'(ctrl_reg.ck);
			if (hits(a, OFF_OE))     ctrl_next.ctl_rdata = 32'(ctrl_reg.oe);
			if (hits(a, OFF_SEL))    ctrl_next.ctl_rdata = 32'(ctrl_reg.sel);
			if (hits(a, OFF_WE))     ctrl_next.ctl_rdata = 32'(ctrl_reg.we);
			if (hits(a, OFF_MR))     ctrl_next.ctl_rdata = 32'(ctrl_reg.mr);
			if (hits(a, OFF_MRR))    ctrl_next.ctl_rdata = 32'(ctrl_reg.mrr);
			if (hits(a, OFF_MPP))    ctrl_next.ctl_rdata = 32'(ctrl_reg.mpp);
			if (hits(a, OFF_VRREN))  ctrl_next.ctl_rdata = 32'(ctrl_reg.vrren);
			if (hits(a, OFF_VPPEN))  ctrl_next.ctl_rdata = 32'(ctrl_reg.vppen);
			if (hits(a, OFF_ADDR))   ctrl_next.ctl_rdata = 32'(ctrl_reg.addr);
			if (hits(a, OFF_WDATA))  ctrl_next.ctl_rdata = 32'(ctrl_reg.wdata);
			if (hits(a, OFF_RDATA))  ctrl_next.ctl_rdata = 32'(ctrl_reg.q);
			if (hits(a, OFF_TIMING)) ctrl_next.ctl_rdata = 32'(ctrl_reg.timing);
		end

		if (ctl_wr) begin
			if (hits(a, OFF_LOCK)) begin
				// A read in flight or starting now keeps the macro; refuse the grab
				if (ctl_writedata_in[0] && (seq_start || ctrl_reg.state != ST_IDLE)) begin
					ctrl_next.lock = 1'b0;
				end else begin
					ctrl_next.lock = ctl_writedata_in[0];
				end
			end
			if (hits(a, OFF_CK))     ctrl_next.ck     = ctl_writedata_in[0];
			if (hits(a, OFF_OE))     ctrl_next.oe     = ctl_writedata_in[0];
			if (hits(a, OFF_SEL))    ctrl_next.sel    = ctl_writedata_in[0];
			if (hits(a, OFF_WE))     ctrl_next.we     = ctl_writedata_in[0];
			if (hits(a, OFF_MR))     ctrl_next.mr     = ctl_writedata_in[MR_W-1:0];
			if (hits(a, OFF_MRR))    ctrl_next.mrr    = ctl_writedata_in[MRR_W-1:0];
			if (hits(a, OFF_MPP))    ctrl_next.mpp    = ctl_writedata_in[MPP_W-1:0];
			if (hits(a, OFF_VRREN))  ctrl_next.vrren  = ctl_writedata_in[0];
			if (hits(a, OFF_VPPEN))  ctrl_next.vppen  = ctl_writedata_in[0];
			if (hits(a, OFF_ADDR))   ctrl_next.addr   = ctl_writedata_in[ADDR_W-1:0];
			if (hits(a, OFF_WDATA))  ctrl_next.wdata  = ctl_writedata_in[DATA_W-1:0];
			if (hits(a, OFF_TIMING)) ctrl_next.timing = ctl_writedata_in[TIM_W-1:0];
		end

		// Supplies always follow their registers
		ctrl_next.pin_mrr   = ctrl_next.mrr;
		ctrl_next.pin_mpp   = ctrl_next.mpp;
		ctrl_next.pin_vrren = ctrl_next.vrren;
		ctrl_next.pin_vppen = ctrl_next.vppen;
		ctrl_next.pin_mr    = ctrl_next.mr;
		if (ctrl_next.lock) begin
			// Software owns the macro pins and alone answers for their timing
			ctrl_next.pin_ck    = ctrl_next.ck;
			ctrl_next.pin_oe    = ctrl_next.oe;
			ctrl_next.pin_sel   = ctrl_next.sel;
			ctrl_next.pin_we    = ctrl_next.we;
			ctrl_next.pin_addr  = ctrl_next.addr;
			ctrl_next.pin_wdata = ctrl_next.wdata;
		end else begin
			ctrl_next.pin_sel   = (ctrl_next.state == ST_SETUP) ||
				(ctrl_next.state == ST_PULSE) || (ctrl_next.state == ST_ACCESS);
			ctrl_next.pin_ck    = (ctrl_next.state == ST_PULSE);
			ctrl_next.pin_oe    = (ctrl_next.state == ST_ACCESS);
			ctrl_next.pin_we    = 1'b0;
			ctrl_next.pin_addr  = ctrl_next.seq_addr;
			ctrl_next.pin_wdata = '0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ctrl_reg           <= '0;
			ctrl_reg.ctl_wait  <= 1'b1;
			ctrl_reg.arr_wait  <= 1'b1;
			ctrl_reg.state     <= ST_IDLE;
			ctrl_reg.timing    <= RST_TIMING;
			ctrl_reg.vrren     <= RST_VRREN;
			ctrl_reg.pin_vrren <= RST_VRREN;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign ctl_readdata_out         = ctrl_reg.ctl_rdata;
	assign ctl_waitrequest_out      = ctrl_reg.ctl_wait;
	assign arr_readdata_out         = ctrl_reg.arr_rdata;
	assign arr_waitrequest_out      = ctrl_reg.arr_wait;
	assign macro_clock_out          = ctrl_reg.pin_ck;
	assign macro_output_enable_out  = ctrl_reg.pin_oe;
	assign macro_select_out         = ctrl_reg.pin_sel;
	assign macro_write_enable_out   = ctrl_reg.pin_we;
	assign macro_mode_out           = ctrl_reg.pin_mr;
	assign macro_address_out        = ctrl_reg.pin_addr;
	assign macro_write_data_out     = ctrl_reg.pin_wdata;
	assign read_regulator_out       = ctrl_reg.pin_mrr;
	assign charge_pump_out          = ctrl_reg.pin_mpp;
	assign read_voltage_enable_out  = ctrl_reg.pin_vrren;
	assign write_voltage_enable_out = ctrl_reg.pin_vppen;

endmodule
`default_nettype wire

// ===== rtl/otpmc_phase_timer.sv
// Down-counter that times one phase of a sequencer read.
// Assumes load_in is a one-cycle pulse and len_in is at least one.
`timescale 1ns/100ps
`default_nettype none
module otpmc_phase_timer
	import otpmc_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk_in,
	input  wire logic               rst_in,
	// Control
	input  wire logic               load_in,
	input  wire logic [PHASE_W-1:0] len_in,
	// Status
	output logic                    expired_out
);
	import otpmc_pkg::*;

	typedef struct packed {
		logic [PHASE_W-1:0] count;
		logic               expired;
	} otpmc_timer_type;

	otpmc_timer_type timer_reg;
	otpmc_timer_type timer_next;

	// Expiry is flagged one cycle early so the phase lasts exactly len_in cycles
	always_comb begin
		timer_next = timer_reg;
		if (load_in) begin
			timer_next.count   = len_in;
			timer_next.expired = (len_in == PHASE_W'(1));
		end else begin
			timer_next.expired = (timer_reg.count == PHASE_W'(2));
			if (timer_reg.count != '0) begin
				timer_next.count = timer_reg.count - PHASE_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			timer_reg <= '0;
		end else begin
			timer_reg <= timer_next;
		end
	end

	assign expired_out = timer_reg.expired;

endmodule
`default_nettype wire

// ===== rtl/otpmc_pkg.sv
// Constants shared by the one-time programmable memory controller.
// Assumes a 10 MHz controller clock and a 32-bit Avalon-MM control bus.
package otpmc_pkg;

	// Clock and reset timing
	localparam int CLK_FREQ_KHZ       = 10000;
	localparam int RESET_HOLD_US      = 150;
	localparam int RESET_HOLD_CYCLES  = (RESET_HOLD_US * CLK_FREQ_KHZ + 999) / 1000;

	// Control bus geometry, byte addressed
	localparam int CTL_AW             = 6;
	localparam int WORD_LSB           = 2;

	// Register byte offsets
	localparam logic [CTL_AW-1:0] OFF_LOCK   = 6'h00;
	localparam logic [CTL_AW-1:0] OFF_CK     = 6'h04;
	localparam logic [CTL_AW-1:0] OFF_OE     = 6'h08;
	localparam logic [CTL_AW-1:0] OFF_SEL    = 6'h0C;
	localparam logic [CTL_AW-1:0] OFF_WE     = 6'h10;
	localparam logic [CTL_AW-1:0] OFF_MR     = 6'h14;
	localparam logic [CTL_AW-1:0] OFF_MRR    = 6'h18;
	localparam logic [CTL_AW-1:0] OFF_MPP    = 6'h1C;
	localparam logic [CTL_AW-1:0] OFF_VRREN  = 6'h20;
	localparam logic [CTL_AW-1:0] OFF_VPPEN  = 6'h24;
	localparam logic [CTL_AW-1:0] OFF_ADDR   = 6'h28;
	localparam logic [CTL_AW-1:0] OFF_WDATA  = 6'h2C;
	localparam logic [CTL_AW-1:0] OFF_RDATA  = 6'h30;
	localparam logic [CTL_AW-1:0] OFF_TIMING = 6'h34;

	// Read-phase timing register layout
	localparam int TIM_SCALE_LSB      = 0;
	localparam int TIM_SCALE_W        = 3;
	localparam int TIM_SETUP_BIT      = 3;
	localparam int TIM_PULSE_BIT      = 4;
	localparam int TIM_ACCESS_BIT     = 5;
	localparam int TIM_W              = 6;
	localparam logic [TIM_W-1:0] RST_TIMING = 6'h01;

	// Reset values of the supply controls
	localparam logic RST_VRREN        = 1'b1;

	// Phase counter width: largest phase is 3 * 2^7 cycles
	localparam int PHASE_W            = 9;

	localparam logic [3:0] FULL_WORD  = 4'hF;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_PULSE  = 3'b010,
		ST_ACCESS = 3'b011,
		ST_DONE   = 3'b100
	} otpmc_state_type;

endpackage
